// ===== rsc_params.svh
// register map, field positions, reset values and timing figures of the regulator supervisor
// assumes a 100 MHz system clock and a 32-bit Avalon-MM slave with byte addresses
`ifndef RSC_PARAMS_SVH
`define RSC_PARAMS_SVH
`define RSC_AW            6
`define RSC_A_CTRL        6'h00
`define RSC_A_STAT        6'h04
`define RSC_A_FLT         6'h08
`define RSC_A_MASK        6'h0C
`define RSC_A_RETRY       6'h10
`define RSC_A_FREQ        6'h14
`define RSC_A_PHASE       6'h18
`define RSC_A_PGDG        6'h1C
`define RSC_A_IOWIN       6'h20
`define RSC_A_IOSUM       6'h24
`define RSC_B_OP_ON       0
`define RSC_B_STRETCH     1
`define RSC_B_LOWPWR      2
`define RSC_B_CLEAR       3
`define RSC_B_RELOAD      4
`define RSC_B_DEVRST      5
`define RSC_B_PROGRAM     6
`define RSC_CTRL_RST      3'h0
`define RSC_MASK_RST      7'h00
`define RSC_RETRY_RST     7'h7F
`define RSC_FREQ_RST      16'h00FA
`define RSC_PHASE_RST     16'h0000
`define RSC_PGDG_RST      16'h1004
`define RSC_IOWIN_RST     16'h0008
`define RSC_SHUT_FAULTS   7'h56
`define RSC_PROG_MAX      2'h3
`define RSC_INIT_CYC      8'h10
`define RSC_TLM_DIV       16'h0064
`define RSC_LOWPWR_SHIFT  4
`define RSC_CLK_MHZ       100
`define RSC_CLK_KHZ       100000
`define RSC_TON_RISE_US   1000
`define RSC_TOFF_FALL_US  2000
`define RSC_RETRY_MS      10
`define RSC_SCL_MIN_KHZ   400
`define RSC_SCL_MAX_KHZ   1000
`define RSC_SYNC_MIN_KHZ  400
`define RSC_SCL_PER_MAX   (`RSC_CLK_KHZ / `RSC_SCL_MIN_KHZ)
`define RSC_SCL_PER_MIN   ((`RSC_CLK_KHZ + `RSC_SCL_MAX_KHZ - 1) / `RSC_SCL_MAX_KHZ)
`define RSC_SYNC_PER_MAX  (`RSC_CLK_KHZ / `RSC_SYNC_MIN_KHZ)
`endif

// ===== rsc_pkg.sv
// types shared by the regulator supervisor and its bench
// assumes nothing beyond the constants header
package rsc_pkg;
  typedef struct packed {
    logic oc;
    logic vin_uvw;
    logic vin_ov;
    logic comm_mem_logic_fault;
    logic ot;
    logic ov;
    logic uv;
  } rsc_fault_t;

  typedef enum logic [2:0] {
    ST_INIT  = 3'b000,
    ST_OFF   = 3'b001,
    ST_RISE  = 3'b010,
    ST_ON    = 3'b011,
    ST_FALL  = 3'b100,
    ST_RETRY = 3'b101
  } rsc_state_t;
endpackage : rsc_pkg

// ===== rsc_top.sv
// supervisory control of a two-phase step-down regulator: enable, power good, faults, sync, config memory
// assumes fault comparators, run, sync and scl come from pins outside the clock domain; the adc code does not
//
// Notes on behaviour
// - regulator enabled when run input is high and the operation-on control bit is set, disabled when the fall time after run goes low ends.
// - power good held low on ov/uv fault, disabled, or on/off sequencing.
// - power good changes while on pass programmable rise and fall deglitch counters.
// - scl stretched only when enabled and measured bus speed is 400 kHz to 1 MHz.
// - management bus serves host clock rates up to 1 MHz.
// - the two switching phases run 180 degrees apart.
// - phase offset to external clock from strap or phase offset register.
// - external clock on sync pin is locked onto by a digital loop.
// - without external clock, period comes from frequency register or strap.
// - stored configuration is protected by a triple-copy majority code.
// - configuration memory accepts at most three programming passes.
// - after reset or reload the stored contents are checked by crc.
// - a crc mismatch keeps the regulator disabled until resolved.
// - each fault can be masked; ov, ot, input ov and oc can be set to retry or latch off.
// - the alert output signals any unmasked fault or warning.
// - each fault and warning has its own sticky status bit.
// - uv, ov, overtemperature, cml, input ov, input uv warning, overcurrent detected.
// - low-power telemetry mode slows the sample strobe sixteenfold.
// - the output current readback window length is programmable.
// - reset, reload or device reset reload settings; power good low until on.
// - clear-faults clears all status at once; present faults set again.
`include "rsc_params.svh"
`timescale 1ns/1ps
module rsc_top #(
  parameter int RISE_CYC  = `RSC_TON_RISE_US * `RSC_CLK_MHZ,
  parameter int FALL_CYC  = `RSC_TOFF_FALL_US * `RSC_CLK_MHZ,
  parameter int RETRY_CYC = `RSC_RETRY_MS * 1000 * `RSC_CLK_MHZ
) (
  input  wire logic               CLK,
  input  wire logic               RST_N,
  input  wire logic [`RSC_AW-1:0] AVS_ADDRESS,
  input  wire logic               AVS_READ,
  input  wire logic               AVS_WRITE,
  input  wire logic [31:0]        AVS_WRITEDATA,
  output logic      [31:0]        AVS_READDATA,
  output logic                    AVS_WAITREQUEST,
  input  wire logic               RUN,
  input  rsc_pkg::rsc_fault_t     FAULT_IN,
  input  wire logic               SYNC_IN,
  input  wire logic               SCL_I,
  output logic                    SCL_O,
  output logic                    SCL_OE,
  input  wire logic               CFG_RES_EN,
  input  wire logic [15:0]        CFG_FREQ,
  input  wire logic [15:0]        CFG_PHASE,
  input  wire logic [11:0]        IOUT_ADC,
  output logic                    REG_EN,
  output logic                    PHASE0_SWITCH_NODE,
  output logic                    PHASE1_SWITCH_NODE,
  output logic                    POWER_GOOD_OUT_O,
  output logic                    POWER_GOOD_OUT_OE,
  output logic                    ALERT_O,
  output logic                    ALERT_OE,
  output logic                    TLM_SAMPLE,
  output logic      [31:0]        IOUT_SUM
);
  if (RISE_CYC < 2 || FALL_CYC < 2 || RETRY_CYC < 2 || RETRY_CYC > 24'hFF_FFFF) begin : g_chk
    $error("rsc_top: sequencing counts out of range");
  end

  localparam logic [23:0] RISE_L  = 24'(RISE_CYC - 1);
  localparam logic [23:0] FALL_L  = 24'(FALL_CYC - 1);
  localparam logic [23:0] RETRY_L = 24'(RETRY_CYC - 1);

  function automatic logic [7:0] crc8(input logic [63:0] d);
    logic [7:0] c;
    c = 8'h00;
    for (int i = 63; i >= 0; i--) begin
      c = {c[6:0], 1'b0} ^ ((c[7] ^ d[i]) ? 8'h07 : 8'h00);
    end
    return c;
  endfunction : crc8

  // pin synchronisers; the first stage is read by the second only
  logic [11:0] pin_a_r, pin_b_r;
  logic [31:0] cfg_a_r, cfg_b_r;
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      pin_a_r <= 12'h000;
      pin_b_r <= 12'h000;
      cfg_a_r <= 32'h0000_0000;
      cfg_b_r <= 32'h0000_0000;
    end else begin
      pin_a_r <= {1'b0, CFG_RES_EN, SCL_I, SYNC_IN, RUN, FAULT_IN};
      pin_b_r <= pin_a_r;
      cfg_a_r <= {CFG_FREQ, CFG_PHASE};
      cfg_b_r <= cfg_a_r;
    end
  end
  rsc_pkg::rsc_fault_t flt_s;
  logic run_s, sync_s, scl_s, res_en_s;
  assign flt_s    = rsc_pkg::rsc_fault_t'(pin_b_r[6:0]);
  assign run_s    = pin_b_r[7];
  assign sync_s   = pin_b_r[8];
  assign scl_s    = pin_b_r[9];
  assign res_en_s = pin_b_r[10];

  // bus slave: one wait cycle, then the answer stands for the accepting edge
  logic wait_r, wr_go, rd_go, cml_ev_r;
  assign wr_go = AVS_WRITE & ~wait_r;
  assign rd_go = AVS_READ & wait_r;
  logic [2:0]  ctrl_r;
  logic [6:0]  mask_r, retry_r, flt_r;
  logic [15:0] freq_r, phase_r, pgdg_r, iowin_r;
  logic [1:0]  prog_cnt_r;
  logic        crc_bad_r, locked_r, pg_r, reg_en_r;
  rsc_pkg::rsc_state_t st_r;
  logic wr_ctrl;
  assign wr_ctrl = wr_go && AVS_ADDRESS == `RSC_A_CTRL;
  logic clr_go, reload_go, devrst_go, prog_go;
  assign clr_go    = wr_ctrl & AVS_WRITEDATA[`RSC_B_CLEAR];
  assign reload_go = wr_ctrl & AVS_WRITEDATA[`RSC_B_RELOAD];
  assign devrst_go = wr_ctrl & AVS_WRITEDATA[`RSC_B_DEVRST];
  assign prog_go   = wr_ctrl & AVS_WRITEDATA[`RSC_B_PROGRAM];

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      wait_r       <= 1'b1;
      AVS_READDATA <= 32'h0000_0000;
    end else begin
      wait_r <= ~((AVS_READ | AVS_WRITE) & wait_r);
      if (rd_go) begin
        case (AVS_ADDRESS)
          `RSC_A_CTRL:  AVS_READDATA <= {29'h0, ctrl_r};
          `RSC_A_STAT:  AVS_READDATA <= {22'h0, st_r, prog_cnt_r, (st_r == rsc_pkg::ST_INIT),
                                         locked_r, crc_bad_r, pg_r, reg_en_r};
          `RSC_A_FLT:   AVS_READDATA <= {25'h0, flt_r};
          `RSC_A_MASK:  AVS_READDATA <= {25'h0, mask_r};
          `RSC_A_RETRY: AVS_READDATA <= {25'h0, retry_r};
          `RSC_A_FREQ:  AVS_READDATA <= {16'h0, freq_r};
          `RSC_A_PHASE: AVS_READDATA <= {16'h0, phase_r};
          `RSC_A_PGDG:  AVS_READDATA <= {16'h0, pgdg_r};
          `RSC_A_IOWIN: AVS_READDATA <= {16'h0, iowin_r};
          `RSC_A_IOSUM: AVS_READDATA <= IOUT_SUM;
          default:      AVS_READDATA <= 32'h0000_0000;
        endcase
      end
    end
  end
  assign AVS_WAITREQUEST = wait_r;

  // configuration memory: three copies per word, majority vote corrects one bad copy
  logic [15:0] nvm_r [4][3];
  logic [7:0]  nvm_crc_r;
  logic [15:0] nvm_fix [4];
  for (genvar w = 0; w < 4; w++) begin : g_ecc
    assign nvm_fix[w] = (nvm_r[w][0] & nvm_r[w][1]) | (nvm_r[w][0] & nvm_r[w][2])
                      | (nvm_r[w][1] & nvm_r[w][2]);
  end
  logic [63:0] live_img, nvm_img;
  assign live_img = {freq_r, phase_r, pgdg_r, iowin_r};
  assign nvm_img  = {nvm_fix[0], nvm_fix[1], nvm_fix[2], nvm_fix[3]};
  logic prog_ok;
  assign prog_ok = prog_cnt_r != `RSC_PROG_MAX;

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      prog_cnt_r <= 2'h0;
      nvm_crc_r  <= 8'h00;
      for (int w = 0; w < 4; w++) begin
        for (int k = 0; k < 3; k++) begin
          nvm_r[w][k] <= 16'h0000;
        end
      end
    end else if (prog_go && prog_ok) begin
      prog_cnt_r <= prog_cnt_r + 2'h1;
      nvm_crc_r  <= crc8(live_img);
      for (int k = 0; k < 3; k++) begin
        nvm_r[0][k] <= freq_r;
        nvm_r[1][k] <= phase_r;
        nvm_r[2][k] <= pgdg_r;
        nvm_r[3][k] <= iowin_r;
      end
    end
  end

  // init sequence and crc check
  logic [7:0] init_cnt_r;
  logic       init_done;
  assign init_done = st_r == rsc_pkg::ST_INIT && init_cnt_r == `RSC_INIT_CYC;
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      init_cnt_r <= 8'h00;
      crc_bad_r  <= 1'b0;
    end else if (st_r != rsc_pkg::ST_INIT) begin
      init_cnt_r <= 8'h00;
    end else begin
      init_cnt_r <= init_cnt_r + 8'h01;
      if (init_done) begin
        crc_bad_r <= prog_cnt_r != 2'h0 && crc8(nvm_img) != nvm_crc_r;
      end
    end
  end

  // software registers; init reloads frequency, phase, deglitch and window from programmed memory, straps override frequency and phase
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      ctrl_r  <= `RSC_CTRL_RST;
      mask_r  <= `RSC_MASK_RST;
      retry_r <= `RSC_RETRY_RST;
      freq_r  <= `RSC_FREQ_RST;
      phase_r <= `RSC_PHASE_RST;
      pgdg_r  <= `RSC_PGDG_RST;
      iowin_r <= `RSC_IOWIN_RST;
    end else if (init_done) begin
      if (prog_cnt_r != 2'h0) begin
        freq_r  <= nvm_fix[0];
        phase_r <= nvm_fix[1];
        pgdg_r  <= nvm_fix[2];
        iowin_r <= nvm_fix[3];
      end
      if (res_en_s) begin
        freq_r  <= cfg_b_r[31:16];
        phase_r <= cfg_b_r[15:0];
      end
    end else if (wr_go) begin
      case (AVS_ADDRESS)
        `RSC_A_CTRL:  ctrl_r  <= AVS_WRITEDATA[2:0];
        `RSC_A_MASK:  mask_r  <= AVS_WRITEDATA[6:0];
        `RSC_A_RETRY: retry_r <= AVS_WRITEDATA[6:0];
        `RSC_A_FREQ:  freq_r  <= AVS_WRITEDATA[15:0];
        `RSC_A_PHASE: phase_r <= AVS_WRITEDATA[15:0];
        `RSC_A_PGDG:  pgdg_r  <= AVS_WRITEDATA[15:0];
        `RSC_A_IOWIN: iowin_r <= AVS_WRITEDATA[15:0];
        default: ;
      endcase
    end
  end

  // cml event: unmapped access or a programming pass beyond the limit
  logic unmapped;
  assign unmapped = AVS_ADDRESS > `RSC_A_IOSUM || AVS_ADDRESS[1:0] != 2'h0;
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      cml_ev_r <= 1'b0;
    end else begin
      cml_ev_r <= (wr_go | (AVS_READ & ~wait_r)) & unmapped | prog_go & ~prog_ok;
    end
  end

  // sticky status; a present fault wins over the clear in the same cycle
  rsc_pkg::rsc_fault_t flt_now;
  always_comb begin
    flt_now     = flt_s;
    flt_now.comm_mem_logic_fault = flt_s.comm_mem_logic_fault | cml_ev_r;
  end
  logic [6:0] flt_set;
  assign flt_set = flt_now & ~mask_r;
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      flt_r <= 7'h00;
    end else begin
      flt_r <= (clr_go ? 7'h00 : flt_r) | flt_set;
    end
  end

  // power sequencer
  logic [23:0] seq_cnt_r;
  logic        latched_r, en_req, shut_now, all_retry;
  assign en_req    = run_s & ctrl_r[`RSC_B_OP_ON] & ~crc_bad_r;
  assign shut_now  = |(flt_set & `RSC_SHUT_FAULTS);
  assign all_retry = (flt_set & `RSC_SHUT_FAULTS & ~retry_r) == 7'h00;
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      st_r      <= rsc_pkg::ST_INIT;
      seq_cnt_r <= 24'h00_0000;
      latched_r <= 1'b0;
    end else begin
      seq_cnt_r <= seq_cnt_r + 24'h00_0001;
      if (!en_req) begin
        latched_r <= 1'b0;
      end
      if (reload_go || devrst_go) begin
        st_r <= rsc_pkg::ST_INIT;
        if (devrst_go) begin
          latched_r <= 1'b0;
        end
      end else begin
        case (st_r)
          rsc_pkg::ST_INIT: begin
            if (init_done) begin
              st_r <= rsc_pkg::ST_OFF;
            end
          end
          rsc_pkg::ST_OFF: begin
            seq_cnt_r <= 24'h00_0000;
            if (en_req && !latched_r && !shut_now) begin
              st_r <= rsc_pkg::ST_RISE;
            end
          end
          rsc_pkg::ST_RISE, rsc_pkg::ST_ON, rsc_pkg::ST_FALL: begin
            if (shut_now || crc_bad_r) begin
              st_r      <= (all_retry && !crc_bad_r) ? rsc_pkg::ST_RETRY : rsc_pkg::ST_OFF;
              latched_r <= !all_retry;
              seq_cnt_r <= 24'h00_0000;
            end else if (st_r != rsc_pkg::ST_FALL && !en_req) begin
              st_r      <= rsc_pkg::ST_FALL;
              seq_cnt_r <= 24'h00_0000;
            end else if (st_r == rsc_pkg::ST_RISE && seq_cnt_r == RISE_L) begin
              st_r <= rsc_pkg::ST_ON;
            end else if (st_r == rsc_pkg::ST_FALL && seq_cnt_r == FALL_L) begin
              st_r <= rsc_pkg::ST_OFF;
            end
          end
          rsc_pkg::ST_RETRY: begin
            if (seq_cnt_r >= RETRY_L && !shut_now) begin
              st_r <= rsc_pkg::ST_OFF;
            end
          end
          default: st_r <= rsc_pkg::ST_INIT;
        endcase
      end
    end
  end

  // power good: disable and sequencing force it low at once, fault and recovery are deglitched
  logic       pg_raw, pg_ok;
  logic [7:0] pg_cnt_r;
  assign pg_ok  = st_r == rsc_pkg::ST_ON;
  assign pg_raw = pg_ok & ~flt_s.ov & ~flt_s.uv;
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      pg_r     <= 1'b0;
      pg_cnt_r <= 8'h00;
    end else if (!pg_ok || pg_raw == pg_r) begin
      pg_cnt_r <= 8'h00;
      if (!pg_ok) begin
        pg_r <= 1'b0;
      end
    end else if (pg_cnt_r >= (pg_raw ? pgdg_r[15:8] : pgdg_r[7:0])) begin
      pg_r     <= pg_raw;
      pg_cnt_r <= 8'h00;
    end else begin
      pg_cnt_r <= pg_cnt_r + 8'h01;
    end
  end

  // switching clock: free running from the frequency setting, or realigned to sync edges
  logic        sync_d_r, sync_rise;
  logic [15:0] gap_r, ext_per_r, sw_cnt_r, per;
  assign sync_rise = sync_s & ~sync_d_r;
  assign per       = locked_r ? ext_per_r : freq_r;
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      sync_d_r  <= 1'b0;
      gap_r     <= 16'h0000;
      ext_per_r <= 16'h0000;
      locked_r  <= 1'b0;
    end else begin
      sync_d_r <= sync_s;
      if (sync_rise) begin
        gap_r     <= 16'h0001;
        ext_per_r <= gap_r;
        locked_r  <= gap_r >= 16'h0002 && gap_r <= 16'(`RSC_SYNC_PER_MAX);
      end else if (gap_r > 16'(`RSC_SYNC_PER_MAX)) begin
        locked_r <= 1'b0;
      end else begin
        gap_r <= gap_r + 16'h0001;
      end
    end
  end
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      sw_cnt_r <= 16'h0000;
    end else if (locked_r && sync_rise) begin
      sw_cnt_r <= (phase_r < ext_per_r && phase_r != 16'h0000) ? ext_per_r - phase_r : 16'h0000;
    end else if (sw_cnt_r + 16'h0001 >= per) begin
      sw_cnt_r <= 16'h0000;
    end else begin
      sw_cnt_r <= sw_cnt_r + 16'h0001;
    end
  end

  // telemetry strobe and output current window
  logic [19:0] tdiv_r;
  logic [15:0] win_cnt_r;
  logic [31:0] acc_r;
  logic [19:0] tlim;
  assign tlim = st_r == rsc_pkg::ST_INIT ? 20'hF_FFFF :
                (ctrl_r[`RSC_B_LOWPWR] ? {`RSC_TLM_DIV, 4'h0} : {4'h0, `RSC_TLM_DIV});
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      tdiv_r     <= 20'h0_0000;
      TLM_SAMPLE <= 1'b0;
      win_cnt_r  <= 16'h0000;
      acc_r      <= 32'h0000_0000;
      IOUT_SUM   <= 32'h0000_0000;
    end else begin
      TLM_SAMPLE <= 1'b0;
      tdiv_r     <= tdiv_r + 20'h0_0001;
      if (tdiv_r + 20'h0_0001 >= tlim) begin
        tdiv_r     <= 20'h0_0000;
        TLM_SAMPLE <= 1'b1;
        if (win_cnt_r + 16'h0001 >= iowin_r) begin
          IOUT_SUM  <= acc_r + {20'h0_0000, IOUT_ADC};
          acc_r     <= 32'h0000_0000;
          win_cnt_r <= 16'h0000;
        end else begin
          acc_r     <= acc_r + {20'h0_0000, IOUT_ADC};
          win_cnt_r <= win_cnt_r + 16'h0001;
        end
      end
    end
  end

  // serial clock stretch while settings reload; only a bus measured at 400 kHz..1 MHz is held
  logic        scl_d_r, speed_ok_r, stretch_r;
  logic [15:0] scl_per_r;
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      scl_d_r    <= 1'b1;
      scl_per_r  <= 16'h0000;
      speed_ok_r <= 1'b0;
      stretch_r  <= 1'b0;
    end else begin
      scl_d_r <= scl_s;
      if (scl_s && !scl_d_r) begin
        scl_per_r  <= 16'h0001;
        speed_ok_r <= scl_per_r >= 16'(`RSC_SCL_PER_MIN) && scl_per_r <= 16'(`RSC_SCL_PER_MAX);
      end else if (scl_per_r != 16'hFFFF) begin
        scl_per_r <= scl_per_r + 16'h0001;
      end
      stretch_r <= ctrl_r[`RSC_B_STRETCH] & speed_ok_r & (st_r == rsc_pkg::ST_INIT)
                 & (stretch_r | ~scl_s);
    end
  end

  // registered pin drivers
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      reg_en_r           <= 1'b0;
      PHASE0_SWITCH_NODE <= 1'b0;
      PHASE1_SWITCH_NODE <= 1'b0;
      POWER_GOOD_OUT_OE  <= 1'b1;
      ALERT_OE           <= 1'b0;
      SCL_OE             <= 1'b0;
    end else begin
      reg_en_r           <= st_r == rsc_pkg::ST_RISE || st_r == rsc_pkg::ST_ON || st_r == rsc_pkg::ST_FALL;
      PHASE0_SWITCH_NODE <= reg_en_r & (sw_cnt_r < (per >> 1));
      PHASE1_SWITCH_NODE <= reg_en_r & (sw_cnt_r >= (per >> 1));
      POWER_GOOD_OUT_OE  <= ~pg_r;
      ALERT_OE           <= |flt_r;
      SCL_OE             <= stretch_r;
    end
  end
  assign REG_EN = reg_en_r;

  // open-drain data levels are always low; only the enables move
  logic od_low_r;
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      od_low_r <= 1'b0;
    end else begin
      od_low_r <= 1'b0;
    end
  end
  assign POWER_GOOD_OUT_O = od_low_r;
  assign ALERT_O          = od_low_r;
  assign SCL_O            = od_low_r;
endmodule : rsc_top

// ===== rsc_host_model.sv
// host side of the management bus: a serial clock source
// assumes the bench ties scl_w to the wired-and of both drivers
`timescale 1ns/1ps
module rsc_host_model (
  input  wire logic clk,
  input  wire logic en,
  input  wire logic scl_w,
  output logic      scl_drv
);
  logic [6:0] cnt_r;
  // halves of 60 cycles give 833 kHz, inside the stretch band
  always_ff @(posedge clk) begin
    if (!en) begin
      scl_drv <= 1'b1;
      cnt_r   <= 7'h00;
    end else if (scl_drv && !scl_w) begin
      // never fight a stretch
      cnt_r <= cnt_r;
    end else if (cnt_r == 7'h3B) begin
      scl_drv <= ~scl_drv;
      cnt_r   <= 7'h00;
    end else begin
      cnt_r <= cnt_r + 7'h01;
    end
  end
endmodule : rsc_host_model

// ===== rsc_top_sva.sv
// pin-level checks of the regulator supervisor
// assumes deglitch settings stay at reset and ot is never masked
`timescale 1ns/1ps
module rsc_top_sva (
  input wire logic           CLK,
  input wire logic           RST_N,
  input wire logic           AVS_READ,
  input wire logic           AVS_WRITE,
  input wire logic           AVS_WAITREQUEST,
  input wire logic           RUN,
  input rsc_pkg::rsc_fault_t FAULT_IN,
  input wire logic           REG_EN,
  input wire logic           PHASE0_SWITCH_NODE,
  input wire logic           PHASE1_SWITCH_NODE,
  input wire logic           POWER_GOOD_OUT_OE,
  input wire logic           ALERT_OE,
  input wire logic           TLM_SAMPLE
);
  default clocking @(posedge CLK); endclocking
  default disable iff (!RST_N);
  logic [10:0] gap_r;
  logic        seen_r;
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      gap_r  <= 11'h000;
      seen_r <= 1'b0;
    end else if (TLM_SAMPLE) begin
      gap_r  <= 11'h000;
      seen_r <= 1'b1;
    end else if (gap_r != 11'h7FF) begin
      gap_r <= gap_r + 11'h001;
    end
  end
  sequence s_req;
    (AVS_READ || AVS_WRITE) && AVS_WAITREQUEST;
  endsequence
  sequence s_ot;
    FAULT_IN.ot [*4];
  endsequence
  sequence s_uv;
    FAULT_IN.uv [*8];
  endsequence
  chk_bus_answer: assert property (s_req |=> !AVS_WAITREQUEST)
    else $error("bus answer late");
  chk_bus_once: assert property (!AVS_WAITREQUEST |=> AVS_WAITREQUEST)
    else $error("waitrequest low too long");
  chk_run_enable: assert property ($rose(REG_EN) |-> $past(RUN, 2))
    else $error("enabled without run");
  chk_phase_off: assert property (!REG_EN [*3] |-> !PHASE0_SWITCH_NODE && !PHASE1_SWITCH_NODE)
    else $error("switching while disabled");
  chk_phase_anti: assert property (REG_EN [*3] |-> PHASE0_SWITCH_NODE != PHASE1_SWITCH_NODE)
    else $error("phases not opposed");
  chk_pg_off: assert property (!REG_EN [*3] |-> POWER_GOOD_OUT_OE)
    else $error("power good while disabled");
  chk_pg_fault: assert property (s_uv |-> ##[0:4] POWER_GOOD_OUT_OE)
    else $error("power good during undervoltage");
  chk_alert_fault: assert property (s_ot |-> ##[0:4] ALERT_OE)
    else $error("no alert on fault");
  chk_tlm_space: assert property (TLM_SAMPLE && seen_r |-> gap_r >= 99 && gap_r <= 1599)
    else $error("sample spacing off");
endmodule : rsc_top_sva
bind rsc_top rsc_top_sva u_rsc_top_sva (
  .CLK(CLK), .RST_N(RST_N), .AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE),
  .AVS_WAITREQUEST(AVS_WAITREQUEST), .RUN(RUN), .FAULT_IN(FAULT_IN), .REG_EN(REG_EN),
  .PHASE0_SWITCH_NODE(PHASE0_SWITCH_NODE), .PHASE1_SWITCH_NODE(PHASE1_SWITCH_NODE),
  .POWER_GOOD_OUT_OE(POWER_GOOD_OUT_OE), .ALERT_OE(ALERT_OE), .TLM_SAMPLE(TLM_SAMPLE));

// ===== tb.sv
// self-checking bench for the regulator supervisor
// assumes two-cycle register accesses and shortened sequencer counts
`include "rsc_params.svh"
`timescale 1ns/1ps
module tb;
  logic                clk, rst_n, rd, wr, wt, run, sync_en, sync_in, host_en;
  logic                scl_drv, scl_oe, scl_o, reg_en, ph0, ph1, pg_oe, al_oe, tlm;
  logic [5:0]          a;
  logic [31:0]         wd, q, v, isum;
  rsc_pkg::rsc_fault_t flt;
  logic [11:0]         adc;
  int                  fail_count, checks_done, tnum;
  wire                 scl_w = scl_drv & (~scl_oe | scl_o);
  rsc_top #(.RISE_CYC(20), .FALL_CYC(30), .RETRY_CYC(40)) u_rsc_top (
    .CLK(clk), .RST_N(rst_n), .AVS_ADDRESS(a), .AVS_READ(rd), .AVS_WRITE(wr),
    .AVS_WRITEDATA(wd), .AVS_READDATA(q), .AVS_WAITREQUEST(wt), .RUN(run), .FAULT_IN(flt),
    .SYNC_IN(sync_in), .SCL_I(scl_w), .SCL_O(scl_o), .SCL_OE(scl_oe), .CFG_RES_EN(1'b0),
    .CFG_FREQ(16'h0000), .CFG_PHASE(16'h0000), .IOUT_ADC(adc), .REG_EN(reg_en),
    .PHASE0_SWITCH_NODE(ph0), .PHASE1_SWITCH_NODE(ph1), .POWER_GOOD_OUT_O(),
    .POWER_GOOD_OUT_OE(pg_oe), .ALERT_O(), .ALERT_OE(al_oe), .TLM_SAMPLE(tlm), .IOUT_SUM(isum));
  rsc_host_model u_rsc_host_model (.clk(clk), .en(host_en), .scl_w(scl_w), .scl_drv(scl_drv));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // sync clock stands still while unused
  always #62.5 sync_in = sync_en & ~sync_in;
  task automatic close_out();
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : close_out
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checks_done++;
    if (g !== e) begin
      fail_count++;
      $display("[ERR] %0t got %h exp %h", $time, g, e);
    end
  endtask : chk
  task automatic tend();
    tnum++;
    $display("test %0d ended", tnum);
  endtask : tend
  task automatic bus(input logic w, input logic [5:0] ad, input logic [31:0] d);
    int k;
    k = 0;
    a  <= ad;
    wd <= d;
    wr <= w;
    rd <= ~w;
    do begin
      @(posedge clk);
      k++;
    end while (wt !== 1'b0 && k < 20);
    v = q;
    wr <= 1'b0;
    rd <= 1'b0;
    @(posedge clk);
    if (k >= 20) begin
      chk(32'(wt), 32'h0000_0000);
      close_out();
    end
  endtask : bus
  task automatic rdc(input logic [5:0] ad, input logic [31:0] e);
    bus(1'b0, ad, 32'h0000_0000);
    chk(v, e);
  endtask : rdc
  task automatic await(ref logic s, input logic e, input int lim);
    int k;
    k = 0;
    while (s !== e && k < lim) begin
      @(posedge clk);
      k++;
    end
    chk(32'(s), 32'(e));
    if (k >= lim) close_out();
  endtask : await
  task automatic gap(ref logic s, input int e);
    int k;
    int t;
    logic p;
    k = 0;
    t = 0;
    p = 1'b1;
    while (t < 2 && k < 9000) begin
      @(posedge clk);
      k++;
      if (s === 1'b1 && p === 1'b0) begin
        t++;
        if (t == 1) k = 0;
      end
      p = s;
    end
    chk(k, e);
  endtask : gap
  initial begin
    fail_count = 0;
    checks_done = 0;
    tnum = 0;
    rst_n = 1'b0;
    a = 6'h00;
    rd = 1'b0;
    wr = 1'b0;
    wd = 32'h0000_0000;
    run = 1'b0;
    flt = '0;
    sync_en = 1'b0;
    sync_in = 1'b0;
    host_en = 1'b0;
    adc = 12'h010;
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    repeat (30) @(posedge clk);
    rdc(`RSC_A_MASK, `RSC_MASK_RST);
    rdc(`RSC_A_RETRY, `RSC_RETRY_RST);
    rdc(`RSC_A_FREQ, `RSC_FREQ_RST);
    rdc(`RSC_A_PGDG, `RSC_PGDG_RST);
    rdc(`RSC_A_STAT, 32'h0000_0080);
    rdc(6'h3C, 32'h0000_0000);
    rdc(`RSC_A_FLT, 32'h0000_0008);
    await(al_oe, 1'b1, 10);
    bus(1'b1, `RSC_A_CTRL, 32'h0000_0008);
    rdc(`RSC_A_FLT, 32'h0000_0000);
    await(al_oe, 1'b0, 10);
    tend();
    run <= 1'b1;
    bus(1'b1, `RSC_A_CTRL, 32'h0000_0001);
    await(reg_en, 1'b1, 20);
    chk(32'(pg_oe), 32'h0000_0001);
    await(pg_oe, 1'b0, 80);
    rdc(`RSC_A_STAT, 32'h0000_0183);
    bus(1'b1, `RSC_A_FREQ, 32'h0000_0064);
    gap(ph0, 100);
    chk(32'(ph0 ^ ph1), 32'h0000_0001);
    sync_en = 1'b1;
    repeat (100) @(posedge clk);
    rdc(`RSC_A_STAT, 32'h0000_018B);
    sync_en = 1'b0;
    tend();
    flt.uv <= 1'b1;
    await(pg_oe, 1'b1, 20);
    repeat (10) @(posedge clk);
    chk(32'(reg_en), 32'h0000_0001);
    bus(1'b1, `RSC_A_CTRL, 32'h0000_0009);
    rdc(`RSC_A_FLT, 32'h0000_0001);
    flt.uv <= 1'b0;
    await(pg_oe, 1'b0, 40);
    bus(1'b1, `RSC_A_CTRL, 32'h0000_0009);
    rdc(`RSC_A_FLT, 32'h0000_0000);
    bus(1'b1, `RSC_A_MASK, 32'h0000_0040);
    flt.oc <= 1'b1;
    repeat (10) @(posedge clk);
    chk(32'(reg_en), 32'h0000_0001);
    rdc(`RSC_A_FLT, 32'h0000_0000);
    flt.oc <= 1'b0;
    tend();
    bus(1'b1, `RSC_A_RETRY, 32'h0000_007B);
    flt.ot <= 1'b1;
    await(reg_en, 1'b0, 10);
    rdc(`RSC_A_FLT, 32'h0000_0004);
    flt.ot <= 1'b0;
    repeat (100) @(posedge clk);
    chk(32'(reg_en), 32'h0000_0000);
    run <= 1'b0;
    repeat (5) @(posedge clk);
    run <= 1'b1;
    await(reg_en, 1'b1, 40);
    bus(1'b1, `RSC_A_RETRY, 32'h0000_007F);
    flt.ov <= 1'b1;
    await(reg_en, 1'b0, 10);
    flt.ov <= 1'b0;
    await(reg_en, 1'b1, 100);
    tend();
    gap(tlm, 100);
    bus(1'b1, `RSC_A_IOWIN, 32'h0000_0004);
    repeat (1000) @(posedge clk);
    rdc(`RSC_A_IOSUM, 32'h0000_0040);
    chk(isum, 32'h0000_0040);
    bus(1'b1, `RSC_A_CTRL, 32'h0000_0005);
    gap(tlm, 1600);
    tend();
    host_en <= 1'b1;
    bus(1'b1, `RSC_A_CTRL, 32'h0000_0003);
    repeat (300) @(posedge clk);
    await(scl_drv, 1'b1, 200);
    await(scl_drv, 1'b0, 200);
    bus(1'b1, `RSC_A_CTRL, 32'h0000_0013);
    await(scl_oe, 1'b1, 30);
    repeat (100) @(posedge clk);
    bus(1'b1, `RSC_A_CTRL, 32'h0000_000B);
    repeat (4) begin
      bus(1'b1, `RSC_A_CTRL, 32'h0000_0043);
      repeat (50) @(posedge clk);
    end
    bus(1'b0, `RSC_A_STAT, 32'h0000_0000);
    chk(32'(v[6:5]), 32'h0000_0003);
    rdc(`RSC_A_FLT, 32'h0000_0008);
    tend();
    close_out();
  end
endmodule : tb
